/* disp_addr_ctrl.sv */
// display ram address counters, line generator, reset and mode control
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module disp_addr_ctrl #(
    parameter int POR_WAIT    = disp_pkg::POR_CYCLES,
    parameter int LINE_CYCLES = disp_pkg::LINE_CYCLES_DEF
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // pins and analogue ready flags
    input  wire logic              rst_pin_n,
    input  wire logic              vlcd_ready,
    input  wire logic              bias_ready,
    // ram write port and scan
    output disp_pkg::ram_wr_t      ram_wr,
    output logic      [7:0]        line_addr,
    output logic      [7:0]        com_index,
    // power control
    output disp_pkg::power_t       power
);
    import disp_pkg::*;

    initial begin
        if (POR_WAIT < 2 || LINE_CYCLES < 2 || LINE_CYCLES > 65535) begin
            $error("disp_addr_ctrl: unsupported parameter value");
        end
    end

    localparam int PW = $clog2(POR_WAIT + 1);
    localparam int MW = $clog2(MODE_WAIT_CYCLES + 1);
    localparam logic [PW-1:0] POR_LAST  = PW'(POR_WAIT - 1);
    localparam logic [MW-1:0] MODE_LOAD = MW'(MODE_WAIT_CYCLES);
    localparam logic [15:0]   LINE_LAST = 16'(LINE_CYCLES - 1);

    // ****************************************
    // synchronisers
    // ****************************************
    logic [1:0] pin_s_q, vlcd_s_q, bias_s_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s_q  <= 2'h0;
            vlcd_s_q <= 2'h0;
            bias_s_q <= 2'h0;
        end else begin
            pin_s_q  <= {pin_s_q[0], rst_pin_n};
            vlcd_s_q <= {vlcd_s_q[0], vlcd_ready};
            bias_s_q <= {bias_s_q[0], bias_ready};
        end
    end
    wire volt_ok = vlcd_s_q[1] & bias_s_q[1];

    // ****************************************
    // reset sources
    // ****************************************
    logic [PW-1:0] por_cnt_q;
    logic          por_done_q, soft_rst_q, sys_rst_q;
    wire           wr_en   = psel & penable & pready & pwrite;
    wire           soft_go = wr_en & (paddr == OFF_CMD) & pwdata[CMD_SOFT_RST];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_cnt_q  <= '0;
            por_done_q <= 1'b0;
            soft_rst_q <= 1'b0;
            sys_rst_q  <= 1'b1;
        end else begin
            if (!por_done_q) begin
                por_cnt_q  <= por_cnt_q + PW'(1);
                por_done_q <= (por_cnt_q == POR_LAST);
            end
            soft_rst_q <= soft_go;
            sys_rst_q  <= !por_done_q | !pin_s_q[1] | soft_rst_q;
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    logic [3:0] ac_q;
    logic [7:0] panel_q, sl_q, cen_q, wrs_q, wre_q, wcs_q, wce_q;
    logic       cmx_q, dc_en_q;
    wire wr_ac   = wr_en & (paddr == OFF_ADDR_CTRL);
    wire wr_pan  = wr_en & (paddr == OFF_PANEL);
    wire wr_mx   = wr_en & (paddr == OFF_COL_MIRROR);
    wire wr_dc   = wr_en & (paddr == OFF_DISP_CTRL);
    wire wr_row  = wr_en & (paddr == OFF_ROW_PTR);
    wire wr_col  = wr_en & (paddr == OFF_COL_PTR);
    wire wr_sl   = wr_en & (paddr == OFF_START_LINE);
    wire wr_cen  = wr_en & (paddr == OFF_COM_END);
    wire wr_wrow = wr_en & (paddr == OFF_WIN_ROW);
    wire wr_wcol = wr_en & (paddr == OFF_WIN_COL);
    wire wr_pix  = wr_en & (paddr == OFF_PIXEL);
    wire wr_byte = wr_en & (paddr == OFF_BYTE);

    // sleep never touches these; only system reset does
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ac_q <= AC_RST; panel_q <= PANEL_RST; cmx_q <= 1'b0; dc_en_q <= 1'b0;
            sl_q <= ZERO8; cen_q <= COM_END_RST;
            wrs_q <= ZERO8; wre_q <= LAST_ROW; wcs_q <= ZERO8; wce_q <= LAST_COL;
        end else if (sys_rst_q) begin
            ac_q <= AC_RST; panel_q <= PANEL_RST; cmx_q <= 1'b0; dc_en_q <= 1'b0;
            sl_q <= ZERO8; cen_q <= COM_END_RST;
            wrs_q <= ZERO8; wre_q <= LAST_ROW; wcs_q <= ZERO8; wce_q <= LAST_COL;
        end else begin
            if (wr_ac)   ac_q    <= pwdata[3:0];
            if (wr_pan)  panel_q <= pwdata[7:0];
            if (wr_mx)   cmx_q   <= pwdata[0];
            if (wr_dc)   dc_en_q <= pwdata[DC_ENABLE];
            if (wr_sl)   sl_q    <= pwdata[7:0];
            if (wr_cen)  cen_q   <= pwdata[7:0];
            if (wr_wrow) begin
                wrs_q <= pwdata[7:0];
                wre_q <= pwdata[15:8];
            end
            if (wr_wcol) begin
                wcs_q <= pwdata[7:0];
                wce_q <= pwdata[15:8];
            end
        end
    end

    // ****************************************
    // window bounds and stepping decode
    // ****************************************
    wire       wrap     = ac_q[AC_WRAP];
    wire       row_wise = ac_q[AC_ROW_WISE];
    wire       row_dec  = ac_q[AC_ROW_DIR];
    wire       outside  = ac_q[AC_OUTSIDE];
    wire       win_on   = wrap & !outside;
    // bounds past the last mirrored column clamp to 0 instead of wrapping
    wire [7:0] mcs      = (wcs_q > MAX_COLUMN) ? ZERO8 : MAX_COLUMN - wcs_q;
    wire [7:0] mce      = (wce_q > MAX_COLUMN) ? ZERO8 : MAX_COLUMN - wce_q;
    wire [7:0] wc_a     = cmx_q ? mcs : wcs_q;
    wire [7:0] wc_b     = cmx_q ? mce : wce_q;
    wire [7:0] wc_lo    = (wc_a < wc_b) ? wc_a : wc_b;
    wire [7:0] wc_hi    = (wc_a < wc_b) ? wc_b : wc_a;
    wire [7:0] row_lo   = win_on ? wrs_q : ZERO8;
    wire [7:0] row_hi   = win_on ? wre_q : LAST_ROW;
    wire [7:0] col_lo   = win_on ? wc_lo : ZERO8;
    wire [7:0] col_hi   = win_on ? wc_hi : LAST_COL;
    wire [7:0] row_first = row_dec ? row_hi : row_lo;

    // ****************************************
    // pixel assembly
    // ****************************************
    logic       half_q;
    logic [7:0] hi_byte_q;
    wire        rgb565  = (panel_q[7:6] == COLOR_RGB565);
    wire        pix_go  = wr_pix | (wr_byte & (!rgb565 | half_q));
    wire [15:0] pix_dat = wr_pix ? pwdata[15:0] :
                          (rgb565 ? {hi_byte_q, pwdata[7:0]} : {8'h00, pwdata[7:0]});
    // any other register write restarts the byte pair; reads leave it alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_q    <= 1'b0;
            hi_byte_q <= ZERO8;
        end else if (sys_rst_q || (wr_en && !wr_byte)) begin
            half_q <= 1'b0;
        end else if (wr_byte && rgb565) begin
            half_q    <= !half_q;
            hi_byte_q <= half_q ? hi_byte_q : pwdata[7:0];
        end
    end

    // ****************************************
    // host address counters
    // ****************************************
    logic [7:0] row_q, col_q;
    wire        row_end  = row_dec ? (row_q == row_lo) : (row_q == row_hi);
    wire [7:0]  row_step = row_end ? (row_dec ? row_hi : row_lo) :
                           (row_dec ? row_q - 8'h01 : row_q + 8'h01);
    wire        col_end  = (col_q == col_hi);
    wire        in_win   = (row_q >= wrs_q) & (row_q <= wre_q) & (col_q >= wc_lo) & (col_q <= wc_hi);
    wire        do_wr    = outside ? !in_win : in_win;
    wire [7:0]  phys_col = cmx_q ? (MAX_COLUMN - col_q) : col_q;
    logic [7:0] row_nx, col_nx;
    always_comb begin
        row_nx = row_q;
        col_nx = col_q;
        if (!wrap) begin
            col_nx = col_end ? col_q : col_q + 8'h01;
        end else if (row_wise) begin
            row_nx = row_step;
            if (row_end) col_nx = col_end ? col_lo : col_q + 8'h01;
        end else if (col_end) begin
            col_nx = col_lo;
            row_nx = row_step;
        end else begin
            col_nx = col_q + 8'h01;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_q <= ZERO8;
            col_q <= ZERO8;
        end else if (sys_rst_q) begin
            row_q <= ZERO8;
            col_q <= ZERO8;
        end else if (wr_row) begin
            row_q <= pwdata[7:0];
        end else if (wr_col) begin
            col_q <= pwdata[7:0];
        end else if (wr_wrow || wr_ac) begin
            row_q <= row_first;
        end else if (wr_wcol) begin
            col_q <= col_lo;
        end else if (pix_go) begin
            row_q <= row_nx;
            col_q <= col_nx;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_wr <= '0;
        end else begin
            ram_wr.we   <= pix_go & do_wr & !sys_rst_q;
            ram_wr.row  <= row_q;
            ram_wr.col  <= phys_col;
            ram_wr.data <= pix_dat;
        end
    end

    // ****************************************
    // operating mode
    // ****************************************
    op_mode_t      om_q;
    logic [MW-1:0] busy_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            om_q   <= OM_RESET;
            busy_q <= '0;
            power  <= '{OM_RESET, 1'b0, 1'b0, 1'b0, 1'b1};
        end else begin
            if (sys_rst_q) om_q <= OM_RESET;
            else if (wr_dc) om_q <= pwdata[DC_ENABLE] ? OM_NORMAL : OM_SLEEP;
            if (sys_rst_q || wr_dc) busy_q <= MODE_LOAD;
            else if (busy_q != '0) busy_q <= busy_q - MW'(1);
            power.op_mode_state <= om_q;
            power.clock_on      <= (om_q == OM_NORMAL);
            power.pump_on       <= (om_q == OM_NORMAL);
            power.drain_on      <= (om_q != OM_NORMAL);
            power.drivers_on    <= (om_q == OM_NORMAL) & volt_ok;
        end
    end

    // ****************************************
    // display line generator
    // ****************************************
    logic [15:0] tick_q;
    logic [7:0]  step_q, line_q;
    wire        scan_on  = (om_q == OM_NORMAL);
    wire        tick     = scan_on & (tick_q == LINE_LAST);
    wire        ymir     = panel_q[PS_ROW_MIRROR];
    wire [8:0]  sum      = {1'b0, sl_q} + {1'b0, cen_q};
    wire [8:0]  sum_mod  = (sum >= LINES_MOD) ? sum - LINES_MOD : sum;
    wire [7:0]  first_ln = ymir ? sum_mod[7:0] : sl_q;
    wire [7:0]  up_ln    = (line_q == LAST_ROW) ? ZERO8 : line_q + 8'h01;
    wire [7:0]  dn_ln    = (line_q == ZERO8) ? LAST_ROW : line_q - 8'h01;
    wire        fld_end  = (step_q == cen_q);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= 16'h0000;
            step_q <= ZERO8;
            line_q <= ZERO8;
        end else if (!scan_on) begin
            tick_q <= 16'h0000;
            step_q <= ZERO8;
            line_q <= first_ln;
        end else begin
            tick_q <= tick ? 16'h0000 : tick_q + 16'h0001;
            if (tick) begin
                step_q <= fld_end ? ZERO8 : step_q + 8'h01;
                line_q <= fld_end ? first_ln : (ymir ? dn_ln : up_ln);
            end
        end
    end
    // the ram is only read here, so row mirroring never alters stored data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_addr <= ZERO8;
            com_index <= ZERO8;
        end else begin
            line_addr <= line_q;
            com_index <= step_q;
        end
    end

    // ****************************************
    // apb slave: one access cycle, no waits
    // ****************************************
    wire [31:0] status = {12'h000, 2'h0, volt_ok, (busy_q != '0), 6'h00, om_q, line_q};
    wire        mapped = (paddr[1:0] == 2'h0) & (paddr <= OFF_STATUS);
    wire [31:0] rd_mux =
        (paddr == OFF_ADDR_CTRL)  ? {28'h0, ac_q} :
        (paddr == OFF_PANEL)      ? {24'h0, panel_q} :
        (paddr == OFF_COL_MIRROR) ? {31'h0, cmx_q} :
        (paddr == OFF_DISP_CTRL)  ? {29'h0, dc_en_q, 2'h0} :
        (paddr == OFF_ROW_PTR)    ? {24'h0, row_q} :
        (paddr == OFF_COL_PTR)    ? {24'h0, col_q} :
        (paddr == OFF_START_LINE) ? {24'h0, sl_q} :
        (paddr == OFF_COM_END)    ? {24'h0, cen_q} :
        (paddr == OFF_WIN_ROW)    ? {16'h0, wre_q, wrs_q} :
        (paddr == OFF_WIN_COL)    ? {16'h0, wce_q, wcs_q} :
        (paddr == OFF_STATUS)     ? status : 32'h0000_0000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & !penable;
            pslverr <= psel & !penable & !mapped;
            prdata  <= (psel & !penable & !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence s_last_col_write;
        pix_go && !wr_row && !wr_col && !wr_ac && !wr_wrow && !wr_wcol && !sys_rst_q && col_q == LAST_COL;
    endsequence
    property p_col_hold;
        @(posedge pclk) disable iff (!presetn) s_last_col_write ##0 !wrap |=> col_q == LAST_COL;
    endproperty
    a_col_hold: assert property (p_col_hold) else $error("column pointer moved past row end");
    property p_col_wrap;
        @(posedge pclk) disable iff (!presetn) s_last_col_write ##0 (wrap && !row_wise && col_lo == ZERO8
            && col_hi == LAST_COL)
            |=> col_q == ZERO8 && row_q == $past(row_step);
    endproperty
    a_col_wrap: assert property (p_col_wrap) else $error("column did not clear with row step");
    property p_row_wrap;
        @(posedge pclk) disable iff (!presetn) s_last_col_write ##0 (wrap && !row_wise && !row_dec
            && col_lo == ZERO8 && col_hi == LAST_COL && row_lo == ZERO8 && row_hi == LAST_ROW
            && row_q == LAST_ROW) |=> row_q == ZERO8;
    endproperty
    a_row_wrap: assert property (p_row_wrap) else $error("row pointer failed to wrap");
    property p_mirror_col;
        @(posedge pclk) disable iff (!presetn) ram_wr.we |-> ram_wr.col == ($past(cmx_q) ?
            8'(MAX_COLUMN - $past(col_q)) : $past(col_q));
    endproperty
    a_mirror_col: assert property (p_mirror_col) else $error("wrong physical column");
    property p_skip_window;
        @(posedge pclk) disable iff (!presetn) pix_go && outside && in_win |=> !ram_wr.we;
    endproperty
    a_skip_window: assert property (p_skip_window) else $error("write landed inside skipped window");
    property p_field_start;
        @(posedge pclk) disable iff (!presetn) tick && fld_end |=> line_q == $past(first_ln) ##1 line_addr == $past(line_q);
    endproperty
    a_field_start: assert property (p_field_start) else $error("field did not start at first line");
    property p_mirror_down;
        @(posedge pclk) disable iff (!presetn) tick && !fld_end && ymir && line_q == ZERO8 |=> line_q == LAST_ROW;
    endproperty
    a_mirror_down: assert property (p_mirror_down) else $error("mirrored line count did not wrap down");
    property p_reset_mode;
        @(posedge pclk) disable iff (!presetn) sys_rst_q |=> om_q == OM_RESET && ac_q == AC_RST ##1
            power.op_mode_state == OM_RESET && !power.drivers_on;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("reset did not restore defaults");
    property p_enable_mode;
        @(posedge pclk) disable iff (!presetn) wr_dc && !sys_rst_q |=> om_q == ($past(pwdata[DC_ENABLE]) ?
            OM_NORMAL : OM_SLEEP) ##1 busy_q != '0;
    endproperty
    a_enable_mode: assert property (p_enable_mode) else $error("display enable did not set mode");
    property p_drivers_ready;
        @(posedge pclk) disable iff (!presetn) !volt_ok |=> !power.drivers_on;
    endproperty
    a_drivers_ready: assert property (p_drivers_ready) else $error("drivers on before voltages ready");
endmodule : disp_addr_ctrl

/* disp_pkg.sv */
// constants, types and register map of the display ram addressing and mode block
package disp_pkg;
    // ****************************************
    // geometry
    // ****************************************
    localparam logic [7:0] LAST_ROW    = 8'h9f;
    localparam logic [7:0] LAST_COL    = 8'h9f;
    localparam logic [7:0] MAX_COLUMN  = 8'h7f;
    localparam logic [8:0] LINES_MOD   = 9'h0a0;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFF_ADDR_CTRL  = 8'h00;
    localparam logic [7:0] OFF_PANEL      = 8'h04;
    localparam logic [7:0] OFF_COL_MIRROR = 8'h08;
    localparam logic [7:0] OFF_DISP_CTRL  = 8'h0c;
    localparam logic [7:0] OFF_ROW_PTR    = 8'h10;
    localparam logic [7:0] OFF_COL_PTR    = 8'h14;
    localparam logic [7:0] OFF_START_LINE = 8'h18;
    localparam logic [7:0] OFF_COM_END    = 8'h1c;
    localparam logic [7:0] OFF_WIN_ROW    = 8'h20;
    localparam logic [7:0] OFF_WIN_COL    = 8'h24;
    localparam logic [7:0] OFF_PIXEL      = 8'h28;
    localparam logic [7:0] OFF_BYTE       = 8'h2c;
    localparam logic [7:0] OFF_CMD        = 8'h30;
    localparam logic [7:0] OFF_STATUS     = 8'h34;
    // ****************************************
    // field positions
    // ****************************************
    localparam int AC_WRAP       = 0;
    localparam int AC_ROW_WISE   = 1;
    localparam int AC_ROW_DIR    = 2;
    localparam int AC_OUTSIDE    = 3;
    localparam int PS_ROW_MIRROR = 3;
    localparam int DC_ENABLE     = 2;
    localparam int CMD_SOFT_RST  = 0;
    localparam logic [1:0] COLOR_RGB565 = 2'h2;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [3:0] AC_RST      = 4'h0;
    localparam logic [7:0] PANEL_RST   = 8'h80;
    localparam logic [7:0] COM_END_RST = 8'h9f;
    localparam logic [7:0] ZERO8       = 8'h00;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS    = 5;
    localparam int POR_TIME_US      = 150000;
    localparam int POR_CYCLES       = (POR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MODE_WAIT_US     = 10;
    localparam int MODE_WAIT_CYCLES = (MODE_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LINE_CYCLES_DEF  = 64;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        OM_RESET  = 2'h0,
        OM_SLEEP  = 2'h2,
        OM_NORMAL = 2'h3
    } op_mode_t;
    typedef struct packed {
        logic        we;
        logic [7:0]  row;
        logic [7:0]  col;
        logic [15:0] data;
    } ram_wr_t;
    typedef struct packed {
        op_mode_t op_mode_state;
        logic     clock_on;
        logic     drivers_on;
        logic     pump_on;
        logic     drain_on;
    } power_t;
endpackage : disp_pkg

/* host_model.sv */
// apb host model that drives the register port of the block
`timescale 1ns/1ps
module host_model (
    // clock
    input  wire logic        pclk,
    // apb request
    output logic      [7:0]  paddr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [31:0] pwdata,
    // apb answer
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        {paddr, psel, penable, pwrite, pwdata} = '0;
    end
    // bounded wait: a dead slave gives ok low, never a hang
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output logic ok);
        ok = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 16 && !ok; i++) begin
            @(posedge pclk);
            ok = (pready === 1'b1);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : host_model

/* tb_display_ram_addressing_and_mode_control.sv */
// self-checking bench of the ram addressing and mode block
`timescale 1ns/1ps
module tb_display_ram_addressing_and_mode_control;
    import disp_pkg::*;
    // ****************************************
    // bench
    // ****************************************
    logic pclk = 0, presetn = 0, rst_pin_n = 1, vlcd_ready = 1, bias_ready = 1;
    logic [7:0]  paddr, line_addr, com_index;
    logic        psel, penable, pwrite, pready, pslverr, er;
    logic [31:0] pwdata, prdata, rd, lfsr_q = 32'hd3e0781c;
    ram_wr_t     ram_wr;
    power_t      power;
    int          errors = 0, n_checks = 0, row_m, col_m, wrap_m, dir_m, mir_m;
    initial forever #2.5 pclk = ~pclk;
    host_model HOST (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
                     .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    disp_addr_ctrl #(.POR_WAIT(20), .LINE_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rst_pin_n(rst_pin_n),
        .vlcd_ready(vlcd_ready), .bias_ready(bias_ready), .ram_wr(ram_wr),
        .line_addr(line_addr), .com_index(com_index), .power(power));
    task automatic close_out;
        if (errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic ok;
        HOST.xfer(wr, a, d, rd, er, ok);
        if (!ok) begin
            errors++;
            close_out();
        end
    endtask : bus
    // pointer setup first, since a pixel lands where the pointers say
    task automatic place(input int r, input int c);
        bus(1'b1, OFF_ROW_PTR, r);
        bus(1'b1, OFF_COL_PTR, c);
        row_m = r;
        col_m = c;
    endtask : place
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // the write strobe stands one cycle after the access edge; two bytes make one 565 pixel
    task automatic pixel(input logic exp_we = 1'b1, input logic two = 1'b0);
        lfsr_q = lfsr(lfsr_q);
        if (two) begin
            bus(1'b1, OFF_BYTE, lfsr_q[15:8]);
            #1;
            check("byte_hold", 0, ram_wr.we);
            bus(1'b1, OFF_BYTE, lfsr_q[7:0]);
        end else begin
            bus(1'b1, OFF_PIXEL, lfsr_q);
        end
        #1;
        check("ram_we", exp_we, ram_wr.we);
        if (exp_we) begin
            check("ram_row", row_m, ram_wr.row);
            check("ram_col", mir_m ? 127 - col_m : col_m, ram_wr.col);
            check("ram_data", lfsr_q[15:0], ram_wr.data);
        end
        if (col_m < 159) col_m++;
        else if (wrap_m) begin
            col_m = 0;
            row_m = dir_m ? (row_m + 159) % 160 : (row_m + 1) % 160;
        end
    endtask : pixel
    // mode changes land within a few cycles; this also waits for the busy window to end
    task automatic settle(input logic [1:0] om);
        // a soft reset lands two edges later than its write
        repeat (4) @(posedge pclk);
        for (int i = 0; i < 900; i++) begin
            bus(1'b0, OFF_STATUS, 0);
            if (rd[16] === 1'b0) break;
        end
        check("status_mode", om, rd[9:8]);
        check("power_mode", om, power.op_mode_state);
        check("drain_on", om != OM_NORMAL, power.drain_on);
        check("drivers_on", om == OM_NORMAL, power.drivers_on);
    endtask : settle
    // follows the scan one line period at a time once a field start is seen
    task automatic scan(input int sl, input int ce, input logic ym);
        int   seen, exp_l, prev_c;
        logic synced;
        seen = -1;
        exp_l = 0;
        prev_c = 0;
        synced = 1'b0;
        for (int i = 0; i < 100; i++) begin
            @(posedge pclk) #1;
            if (com_index != seen) begin
                prev_c = seen;
                seen = com_index;
                if (synced && seen != 0) check("com_step", prev_c + 1, seen);
                if (seen == 0) synced = 1'b1;
                exp_l = (seen == 0) ? (ym ? (sl + ce) % 160 : sl) : (ym ? (exp_l + 159) % 160 : (exp_l + 1) % 160);
                if (synced) check("line_addr", exp_l, line_addr);
            end
        end
        check("scan_synced", 1, synced);
    endtask : scan
    initial begin
        {wrap_m, dir_m, mir_m} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (30) @(posedge pclk);
        settle(OM_RESET);
        bus(1'b0, OFF_COM_END, 0);
        check("com_end_default", COM_END_RST, rd);
        bus(1'b0, 8'h38, 0);
        check("unmapped_err", 1, er);
        place(5, 158);
        repeat (3) pixel();
        bus(1'b1, OFF_ADDR_CTRL, 5);
        {wrap_m, dir_m} = {32'd1, 32'd1};
        place(0, 159);
        repeat (2) pixel();
        bus(1'b1, OFF_ADDR_CTRL, 1);
        dir_m = 0;
        place(159, 159);
        repeat (2) pixel();
        bus(1'b1, OFF_COL_MIRROR, 1);
        mir_m = 1;
        place(7, 10);
        pixel();
        bus(1'b1, OFF_DISP_CTRL, 4);
        settle(OM_NORMAL);
        bus(1'b1, OFF_DISP_CTRL, 0);
        settle(OM_SLEEP);
        bus(1'b0, OFF_COL_MIRROR, 0);
        check("sleep_keeps", 1, rd[0]);
        bus(1'b1, OFF_CMD, 1);
        settle(OM_RESET);
        bus(1'b0, OFF_COL_MIRROR, 0);
        check("reset_clears", 0, rd[0]);
        {wrap_m, dir_m, mir_m} = '0;
        bus(1'b1, OFF_WIN_ROW, 32'h0000_140a);
        bus(1'b1, OFF_WIN_COL, 32'h0000_140a);
        place(5, 5);
        pixel(1'b0);
        place(15, 15);
        pixel();
        bus(1'b1, OFF_ADDR_CTRL, 8);
        place(15, 15);
        pixel(1'b0);
        place(5, 5);
        pixel(1'b1, 1'b1);
        bus(1'b1, OFF_START_LINE, 158);
        bus(1'b1, OFF_COM_END, 3);
        bus(1'b1, OFF_DISP_CTRL, 4);
        settle(OM_NORMAL);
        scan(158, 3, 1'b0);
        bus(1'b1, OFF_PANEL, 32'h88);
        scan(158, 3, 1'b1);
        vlcd_ready <= 1'b0;
        repeat (4) @(posedge pclk);
        check("drivers_idle", 0, power.drivers_on);
        vlcd_ready <= 1'b1;
        repeat (4) @(posedge pclk);
        check("drivers_back", 1, power.drivers_on);
        rst_pin_n <= 1'b0;
        repeat (4) @(posedge pclk);
        rst_pin_n <= 1'b1;
        settle(OM_RESET);
        close_out();
    end
endmodule : tb_display_ram_addressing_and_mode_control
